// ==== include/ubrg_pkg.sv ====
// Purpose: Constants for the serial channel bit-rate generator
// Assumes: 40 MHz system clock, one clock domain
// Notes:   Prescaler taps are powers of two of the system clock
package ubrg_pkg;
  localparam int unsigned CNT_W          = 5;
  localparam int unsigned PRE_W          = 4;
  localparam int unsigned SEL_HI_POS     = 7;
  localparam int unsigned SEL_LO_POS     = 6;
  localparam int unsigned POWER_POS      = 7;
  localparam int unsigned TX_EN_POS      = 6;
  localparam int unsigned RX_EN_POS      = 5;
  localparam logic [CNT_W-1:0] CNT_RESET = 5'h00;
  localparam logic [PRE_W-1:0] PRE_RESET = 4'h0;
  localparam logic [CNT_W-1:0] DIV_MIN   = 5'h01;
  localparam logic [3:0] TAP_SEL0        = 4'h0;
  localparam logic [3:0] TAP_SEL1        = 4'h1;
  localparam logic [3:0] TAP_SEL2        = 4'h3;
  localparam logic [3:0] TAP_SEL3        = 4'h7;

  typedef enum logic [0:0] {
    UBRG_RX_IDLE = 1'b0,
    UBRG_RX_RUN  = 1'b1
  } ubrg_rx_state_t;
endpackage : ubrg_pkg

// ==== rtl/ubrg_top.sv ====
// Purpose: Bit-rate generator with separate transmit and receive counters
// Assumes: Control bits come from same-clock logic; base clock is an
//          enable pulse on CLOCK_IN
// Notes:   Summary of operation
// Summary of operation
// - Clock selector feeds 5-bit programmable counters timing serial bits.
// - Two independent 5-bit counters: one transmit, one receive.
// - Select field bits 7:6 picks base clock; passed only when powered.
// - Base clock output held low while channel power bit is 0.
// - Transmit counter cleared and stopped if power or transmit enable 0.
// - Transmit counter counts base clocks once power and enable are 1.
// - First transmit data write clears the transmit counter to zero.
// - Receive counter cleared and stopped if power or receive enable 0.
// - Receive counter starts only on detected start bit.
// - Receive counter stops after a frame until next start bit.
`timescale 1ns/10ps
module ubrg_top
  import ubrg_pkg::*;
(
  input  wire logic             CLOCK_IN,
  input  wire logic             SRST_IN,
  input  wire logic [1:0]       BASE_CLOCK_SELECT_IN,
  input  wire logic             CHANNEL_POWER_IN,
  input  wire logic             TRANSMIT_ENABLE_IN,
  input  wire logic             RECEIVE_ENABLE_IN,
  input  wire logic [CNT_W-1:0] TX_DIVISOR_IN,
  input  wire logic [CNT_W-1:0] RX_DIVISOR_IN,
  input  wire logic             TX_FIRST_WRITE_IN,
  input  wire logic             RX_START_DETECT_IN,
  input  wire logic             RX_FRAME_DONE_IN,
  output logic                  BASE_CLOCK_OUT,
  output logic                  TX_BIT_TICK_OUT,
  output logic                  RX_BIT_TICK_OUT,
  output logic [CNT_W-1:0]      TX_COUNT_OUT,
  output logic [CNT_W-1:0]      RX_COUNT_OUT,
  output logic                  RX_RUNNING_OUT
);

  // Counter step: reload to zero at divisor minus one, report the wrap
  function automatic logic [CNT_W:0] cnt_step(
    input logic [CNT_W-1:0] cur,
    input logic [CNT_W-1:0] div
  );
    logic [CNT_W-1:0] lim;
    lim = (div < DIV_MIN) ? DIV_MIN : div;
    if (cur >= lim - DIV_MIN) begin
      cnt_step = {1'b1, CNT_RESET};
    end else begin
      cnt_step = {1'b0, CNT_W'(cur + DIV_MIN)};
    end
  endfunction : cnt_step

  logic [PRE_W-1:0] pre;
  logic [PRE_W-1:0] next_pre;
  logic             base_en;
  logic             next_base_en;
  logic [3:0]       tap;

  // Prescaler and base clock gate
  always_comb begin
    case (BASE_CLOCK_SELECT_IN)
      2'b00:   tap = TAP_SEL0;
      2'b01:   tap = TAP_SEL1;
      2'b10:   tap = TAP_SEL2;
      default: tap = TAP_SEL3;
    endcase
    next_pre     = PRE_RESET;
    next_base_en = 1'b0;
    if (CHANNEL_POWER_IN) begin
      next_pre     = PRE_W'(pre + 4'h1);
      next_base_en = ((pre & tap) == tap);
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      pre     <= PRE_RESET;
      base_en <= 1'b0;
    end else begin
      pre     <= next_pre;
      base_en <= next_base_en;
    end
  end

  assign BASE_CLOCK_OUT = base_en;

  logic [CNT_W-1:0] tx_cnt;
  logic [CNT_W-1:0] next_tx_cnt;
  logic             tx_tick;
  logic             next_tx_tick;
  logic [CNT_W:0]   tx_step;
  logic             tx_on;

  // Transmit counter
  always_comb begin
    tx_on        = CHANNEL_POWER_IN & TRANSMIT_ENABLE_IN;
    tx_step      = cnt_step(tx_cnt, TX_DIVISOR_IN);
    next_tx_cnt  = tx_cnt;
    next_tx_tick = 1'b0;
    if (!tx_on) begin
      next_tx_cnt = CNT_RESET;
    end else if (TX_FIRST_WRITE_IN) begin
      next_tx_cnt = CNT_RESET;
    end else if (base_en) begin
      next_tx_cnt  = tx_step[CNT_W-1:0];
      next_tx_tick = tx_step[CNT_W];
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      tx_cnt  <= CNT_RESET;
      tx_tick <= 1'b0;
    end else begin
      tx_cnt  <= next_tx_cnt;
      tx_tick <= next_tx_tick;
    end
  end

  ubrg_rx_state_t   rx_state;
  ubrg_rx_state_t   next_rx_state;
  logic [CNT_W-1:0] rx_cnt;
  logic [CNT_W-1:0] next_rx_cnt;
  logic             rx_tick;
  logic             next_rx_tick;
  logic [CNT_W:0]   rx_step;
  logic             rx_on;

  // Receive counter: runs from start bit to end of frame
  always_comb begin
    rx_on         = CHANNEL_POWER_IN & RECEIVE_ENABLE_IN;
    rx_step       = cnt_step(rx_cnt, RX_DIVISOR_IN);
    next_rx_state = rx_state;
    next_rx_cnt   = rx_cnt;
    next_rx_tick  = 1'b0;
    if (!rx_on) begin
      next_rx_state = UBRG_RX_IDLE;
      next_rx_cnt   = CNT_RESET;
    end else begin
      case (rx_state)
        UBRG_RX_IDLE: begin
          next_rx_cnt = CNT_RESET;
          if (RX_START_DETECT_IN) begin
            next_rx_state = UBRG_RX_RUN;
          end
        end
        UBRG_RX_RUN: begin
          if (RX_FRAME_DONE_IN) begin
            next_rx_state = UBRG_RX_IDLE;
            next_rx_cnt   = CNT_RESET;
          end else if (base_en) begin
            next_rx_cnt  = rx_step[CNT_W-1:0];
            next_rx_tick = rx_step[CNT_W];
          end
        end
        default: begin
          next_rx_state = UBRG_RX_IDLE;
          next_rx_cnt   = CNT_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      rx_state <= UBRG_RX_IDLE;
      rx_cnt   <= CNT_RESET;
      rx_tick  <= 1'b0;
    end else begin
      rx_state <= next_rx_state;
      rx_cnt   <= next_rx_cnt;
      rx_tick  <= next_rx_tick;
    end
  end

  assign TX_BIT_TICK_OUT = tx_tick;
  assign RX_BIT_TICK_OUT = rx_tick;
  assign TX_COUNT_OUT    = tx_cnt;
  assign RX_COUNT_OUT    = rx_cnt;
  assign RX_RUNNING_OUT  = (rx_state == UBRG_RX_RUN);

  // Checks: base clock gate and prescaler
  AST_BASE_LOW: assert property (@(posedge CLOCK_IN)
    disable iff (SRST_IN)
    !CHANNEL_POWER_IN |=> !BASE_CLOCK_OUT)
    else $error("Base clock active while unpowered");

  AST_BASE_PWR: assert property (@(posedge CLOCK_IN)
    disable iff (SRST_IN)
    BASE_CLOCK_OUT |-> $past(CHANNEL_POWER_IN))
    else $error("Base clock pulse without power");

  AST_BASE_SEL0: assert property (@(posedge CLOCK_IN)
    disable iff (SRST_IN)
    (CHANNEL_POWER_IN && BASE_CLOCK_SELECT_IN == 2'b00)[*3]
    |-> BASE_CLOCK_OUT)
    else $error("Undivided base clock missing");

  AST_BASE_SEL1: assert property (@(posedge CLOCK_IN)
    disable iff (SRST_IN)
    (CHANNEL_POWER_IN && BASE_CLOCK_SELECT_IN == 2'b01)[*3]
    ##0 !BASE_CLOCK_OUT |=> BASE_CLOCK_OUT)
    else $error("Half-rate base clock missing");

  AST_BASE_DIV: assert property (@(posedge CLOCK_IN)
    disable iff (SRST_IN)
    BASE_CLOCK_OUT && BASE_CLOCK_SELECT_IN != 2'b00
    && $past(BASE_CLOCK_SELECT_IN) != 2'b00 |=> !BASE_CLOCK_OUT)
    else $error("Divided base clock pulsed twice in a row");

  // Checks: transmit counter
  AST_TX_HOLD: assert property (@(posedge CLOCK_IN)
    disable iff (SRST_IN)
    !(CHANNEL_POWER_IN && TRANSMIT_ENABLE_IN)
    |=> TX_COUNT_OUT == 5'h00 && !TX_BIT_TICK_OUT)
    else $error("Transmit counter not held");

  AST_TX_COUNT: assert property (@(posedge CLOCK_IN)
    disable iff (SRST_IN)
    CHANNEL_POWER_IN && TRANSMIT_ENABLE_IN && !TX_FIRST_WRITE_IN
    && BASE_CLOCK_OUT && !tx_step[CNT_W]
    |=> TX_COUNT_OUT == $past(TX_COUNT_OUT) + 5'h01)
    else $error("Transmit counter did not advance");

  AST_TX_WAIT: assert property (@(posedge CLOCK_IN)
    disable iff (SRST_IN)
    CHANNEL_POWER_IN && TRANSMIT_ENABLE_IN && !TX_FIRST_WRITE_IN
    && !BASE_CLOCK_OUT |=> $stable(TX_COUNT_OUT) && !TX_BIT_TICK_OUT)
    else $error("Transmit counter moved without base clock");

  AST_TX_WRAP: assert property (@(posedge CLOCK_IN)
    disable iff (SRST_IN)
    CHANNEL_POWER_IN && TRANSMIT_ENABLE_IN && !TX_FIRST_WRITE_IN
    && BASE_CLOCK_OUT && tx_step[CNT_W]
    |=> TX_COUNT_OUT == 5'h00 && TX_BIT_TICK_OUT)
    else $error("Transmit counter did not reload with a tick");

  AST_TX_CLEAR: assert property (@(posedge CLOCK_IN)
    disable iff (SRST_IN)
    TX_FIRST_WRITE_IN |=> TX_COUNT_OUT == 5'h00 && !TX_BIT_TICK_OUT)
    else $error("First write did not clear counter");

  AST_TICK_ONE: assert property (@(posedge CLOCK_IN)
    disable iff (SRST_IN)
    TX_BIT_TICK_OUT |-> TX_COUNT_OUT == 5'h00 && $past(BASE_CLOCK_OUT))
    else $error("Transmit tick without a reload");

  AST_NO_TICK: assert property (@(posedge CLOCK_IN)
    disable iff (SRST_IN)
    !BASE_CLOCK_OUT |=> !TX_BIT_TICK_OUT && !RX_BIT_TICK_OUT)
    else $error("Bit tick without base clock");

  // Checks: receive counter
  AST_RX_HOLD: assert property (@(posedge CLOCK_IN)
    disable iff (SRST_IN)
    !(CHANNEL_POWER_IN && RECEIVE_ENABLE_IN)
    |=> RX_COUNT_OUT == 5'h00 && !RX_RUNNING_OUT)
    else $error("Receive counter not held");

  AST_RX_START: assert property (@(posedge CLOCK_IN)
    disable iff (SRST_IN)
    !RX_RUNNING_OUT && !RX_START_DETECT_IN |=> !RX_RUNNING_OUT
    && RX_COUNT_OUT == 5'h00)
    else $error("Receive counter ran without start bit");

  AST_RX_GO: assert property (@(posedge CLOCK_IN)
    disable iff (SRST_IN)
    CHANNEL_POWER_IN && RECEIVE_ENABLE_IN && !RX_RUNNING_OUT
    && RX_START_DETECT_IN |=> RX_RUNNING_OUT && RX_COUNT_OUT == 5'h00)
    else $error("Start bit did not start receive counter");

  AST_RX_COUNT: assert property (@(posedge CLOCK_IN)
    disable iff (SRST_IN)
    CHANNEL_POWER_IN && RECEIVE_ENABLE_IN && RX_RUNNING_OUT
    && !RX_FRAME_DONE_IN && BASE_CLOCK_OUT && !rx_step[CNT_W]
    |=> RX_COUNT_OUT == $past(RX_COUNT_OUT) + 5'h01)
    else $error("Receive counter did not advance");

  AST_RX_WAIT: assert property (@(posedge CLOCK_IN)
    disable iff (SRST_IN)
    CHANNEL_POWER_IN && RECEIVE_ENABLE_IN && RX_RUNNING_OUT
    && !RX_FRAME_DONE_IN && !BASE_CLOCK_OUT |=> $stable(RX_COUNT_OUT))
    else $error("Receive counter moved without base clock");

  AST_RX_WRAP: assert property (@(posedge CLOCK_IN)
    disable iff (SRST_IN)
    CHANNEL_POWER_IN && RECEIVE_ENABLE_IN && RX_RUNNING_OUT
    && !RX_FRAME_DONE_IN && BASE_CLOCK_OUT && rx_step[CNT_W]
    |=> RX_COUNT_OUT == 5'h00 && RX_BIT_TICK_OUT)
    else $error("Receive counter did not reload with a tick");

  AST_RX_STOP: assert property (@(posedge CLOCK_IN)
    disable iff (SRST_IN)
    RX_RUNNING_OUT && RX_FRAME_DONE_IN
    |=> !RX_RUNNING_OUT && RX_COUNT_OUT == 5'h00)
    else $error("Receive counter kept running after frame");

  AST_RX_IDLE: assert property (@(posedge CLOCK_IN)
    disable iff (SRST_IN)
    !RX_RUNNING_OUT |=> !RX_BIT_TICK_OUT)
    else $error("Receive tick while stopped");

  AST_RX_TICK_ONE: assert property (@(posedge CLOCK_IN)
    disable iff (SRST_IN)
    RX_BIT_TICK_OUT |-> RX_COUNT_OUT == 5'h00
    && $past(BASE_CLOCK_OUT) && $past(RX_RUNNING_OUT))
    else $error("Receive tick without a reload");

  // Checks: reset
  AST_RESET: assert property (@(posedge CLOCK_IN)
    SRST_IN |=> TX_COUNT_OUT == 5'h00 && RX_COUNT_OUT == 5'h00
    && !BASE_CLOCK_OUT && !RX_RUNNING_OUT
    && !TX_BIT_TICK_OUT && !RX_BIT_TICK_OUT)
    else $error("Reset did not clear generator");

endmodule : ubrg_top

// ==== tb/ubrg_shift_model.sv ====
// Purpose: Receive shift logic stand-in that frames the bit ticks
// Assumes: One clock; ticks are one-cycle pulses
// Notes:   Start one cycle after go, done after BITS ticks
`timescale 1ns/10ps
module ubrg_shift_model #(parameter int BITS = 3) (
  input  wire logic clock_in,
  input  wire logic go_in,
  input  wire logic tick_in,
  output logic      start_out,
  output logic      done_out
);
  int n = 0;
  initial begin
    start_out = 1'b0;
    done_out  = 1'b0;
  end
  always @(posedge clock_in) begin
    start_out <= go_in;
    done_out  <= 1'b0;
    if (go_in) n <= BITS;
    else if (tick_in === 1'b1 && n > 0) begin
      n <= n - 1;
      if (n == 1) done_out <= 1'b1;
    end
  end
endmodule : ubrg_shift_model

// ==== tb/ubrg_top_tb.sv ====
// Purpose: Self-checking bench for the bit-rate generator
// Assumes: Inputs change by non-blocking assignment at the rising edge
// Notes:   Outputs are sampled at the falling edge
`timescale 1ns/10ps
module ubrg_top_tb import ubrg_pkg::*; ;
  logic clk = 1'b0, srst = 1'b1, pwr = 1'b0, txe = 1'b0, rxe = 1'b0;
  logic fw = 1'b0, go = 1'b0, base, txt, rxt, run, start, done;
  logic [1:0] sel = 2'h0;
  logic [CNT_W-1:0] txd = 5'h01, rxd = 5'h01, txc, rxc;
  logic [16:0] rnd = 17'h1_6E4D;
  int err_total = 0, checks_done = 0, n;
  initial forever #12.5 clk = ~clk;
  ubrg_top dut (.CLOCK_IN(clk), .SRST_IN(srst), .BASE_CLOCK_SELECT_IN(sel),
    .CHANNEL_POWER_IN(pwr), .TRANSMIT_ENABLE_IN(txe),
    .RECEIVE_ENABLE_IN(rxe), .TX_DIVISOR_IN(txd), .RX_DIVISOR_IN(rxd),
    .TX_FIRST_WRITE_IN(fw), .RX_START_DETECT_IN(start),
    .RX_FRAME_DONE_IN(done), .BASE_CLOCK_OUT(base), .TX_BIT_TICK_OUT(txt),
    .RX_BIT_TICK_OUT(rxt), .TX_COUNT_OUT(txc), .RX_COUNT_OUT(rxc),
    .RX_RUNNING_OUT(run));
  ubrg_shift_model #(.BITS(3)) peer (.clock_in(clk), .go_in(go),
    .tick_in(rxt), .start_out(start), .done_out(done));
  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction : lfsr
  // Cycles between ticks: divisor base clocks of 2**sel system clocks
  function automatic int period(input logic [4:0] d, input logic [1:0] s);
    return ((d == 5'h00) ? 1 : int'(d)) << s;
  endfunction : period
  task check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task measure(input bit rx, output int c);
    repeat (600) begin
      @(negedge clk);
      if ((rx ? rxt : txt) === 1'b1) break;
    end
    c = 0;
    repeat (600) begin
      @(negedge clk);
      c++;
      if ((rx ? rxt : txt) === 1'b1) break;
    end
  endtask : measure
  task test_done;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  initial begin
    repeat (50000) @(posedge clk);
    err_total++;
    test_done;
  end
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    check({base, txc, rxc, run}, 16'h0000);
    @(posedge clk);
    txe <= 1'b1;
    rxe <= 1'b1;
    repeat (20) @(negedge clk);
    check({base, txc, rxc}, 16'h0000);
    @(posedge clk);
    pwr <= 1'b1;
    repeat (40) @(negedge clk);
    check({run, rxc}, 16'h0000);
    for (int k = 0; k < 6; k++) begin
      rnd = lfsr(rnd);
      @(posedge clk);
      pwr <= 1'b0;
      sel <= rnd[1:0];
      txd <= (k == 0) ? 5'h00 : (k == 1) ? 5'h1F : rnd[6:2];
      rxd <= (k == 0) ? 5'h1F : rnd[11:7];
      @(posedge clk);
      pwr <= 1'b1;
      measure(1'b0, n);
      check(16'(n), 16'(period(txd, sel)));
      @(posedge clk);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      measure(1'b1, n);
      check(16'(n), 16'(period(rxd, sel)));
      repeat (1200) begin
        @(negedge clk);
        if (run === 1'b0) break;
      end
      n = 0;
      repeat (300) begin
        @(negedge clk);
        n += (rxt === 1'b1);
      end
      check({run, n[14:0]}, 16'h0000);
    end
    @(posedge clk);
    sel <= 2'h0;
    txd <= 5'h1F;
    repeat (10) @(posedge clk);
    fw <= 1'b1;
    @(posedge clk);
    fw <= 1'b0;
    @(negedge clk);
    check(txc, 16'h0000);
    @(negedge clk);
    check(txc, 16'h0001);
    repeat (5) @(posedge clk);
    txe <= 1'b0;
    rxe <= 1'b0;
    repeat (2) @(negedge clk);
    check({txc, rxc, run}, 16'h0000);
    test_done;
  end
endmodule : ubrg_top_tb
